// >>> pkg/ddrsp_pkg.sv
// shared constants for the ddr two-word burst sram port
package ddrsp_pkg;

	// ------------------------------------------------------------
	// data organisation
	// ------------------------------------------------------------
	localparam int DATA_W_X18 = 18;
	localparam int DATA_W_X36 = 36;
	localparam int ADDR_W_X18 = 21;
	localparam int ADDR_W_X36 = 20;
	localparam int BURST_WORDS = 2;

	// ------------------------------------------------------------
	// read latency in k cycles
	// ------------------------------------------------------------
	localparam int LAT_LONG_CYC = 2;
	localparam int LAT_SHORT_CYC = 1;

	// ------------------------------------------------------------
	// synchroniser, status and reset values
	// ------------------------------------------------------------
	localparam int SYNC_STAGES = 3;
	localparam int COUNT_W = 16;
	localparam logic [15:0] COUNT_STEP = 16'h0001;
	localparam logic OE_OFF = 1'h1;
	localparam logic OE_ON = 1'h0;
	localparam logic RST_RELEASE = 1'h1;

endpackage

// >>> pkg/ddrsp_mem_if.sv
// carrier between the link front end and the storage array
`timescale 1ns/10ps
interface ddrsp_mem_if #(
	parameter int ADDR_W = ddrsp_pkg::ADDR_W_X18,
	parameter int DATA_W = ddrsp_pkg::DATA_W_X18
);
	logic we;
	logic [ADDR_W-1:0] waddr;
	logic [ddrsp_pkg::BURST_WORDS*DATA_W-1:0] wdata;
	logic [ADDR_W-1:0] raddr;
	logic [ddrsp_pkg::BURST_WORDS*DATA_W-1:0] rdata;

	modport ctrl (
		output we,
		output waddr,
		output wdata,
		output raddr,
		input rdata
	);

	modport store (
		input we,
		input waddr,
		input wdata,
		input raddr,
		output rdata
	);
endinterface

// >>> hw/ddrsp_sync.sv
// three-stage synchroniser whose output moves once stages two and three agree
`timescale 1ns/10ps
module ddrsp_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	input wire logic enable,
	// level in and out
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] held;
	} ddrsp_sync_t;

	ddrsp_sync_t st;
	ddrsp_sync_t next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = din;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.held[i] = st.s3[i];
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else if (enable) begin
			st <= next_st;
		end
	end

	assign dout = st.held;

endmodule

// >>> hw/ddrsp_array.sv
// storage array, written in one self-timed step with both burst words
`timescale 1ns/10ps
module ddrsp_array #(
	parameter int ADDR_W = ddrsp_pkg::ADDR_W_X18,
	parameter int DATA_W = ddrsp_pkg::DATA_W_X18
) (
	// link clock
	input wire logic k_clk,
	// access port
	ddrsp_mem_if.store mem
);

	localparam int DEPTH = 1 << ADDR_W;
	localparam int LINE_W = ddrsp_pkg::BURST_WORDS * DATA_W;

	logic [LINE_W-1:0] store [DEPTH];

	// both words of a burst land together, no strobe timing from outside
	always_ff @(posedge k_clk) begin
		if (mem.we) begin
			store[mem.waddr] <= mem.wdata;
		end
	end

	assign mem.rdata = store[mem.raddr];

endmodule

// >>> hw/ddrsp_top.sv
// ddr two-word burst sram port: link capture, read launch, echo clocks, status
`timescale 1ns/10ps
module ddrsp_top #(
	parameter int DATA_W = ddrsp_pkg::DATA_W_X18,
	parameter int ADDR_W = ddrsp_pkg::ADDR_W_X18
) (
	// system clock, reset and enable
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clock_enable,
	// link clocks from the controller
	input wire logic k_clk,
	input wire logic k_clk_n,
	// command
	input wire logic cmd_load_n,
	input wire logic cmd_write_n,
	input wire logic [ADDR_W-1:0] cmd_addr,
	// shared data pins
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic [DATA_W-1:0] dq_oe_n,
	// echo clocks and valid flag
	output logic read_echo_clock,
	output logic read_echo_clock_n,
	output logic read_valid_flag,
	// latency strap
	input wire logic latency_select_input,
	// status in the system domain
	output logic latency_long,
	output logic [ddrsp_pkg::COUNT_W-1:0] read_count,
	output logic [ddrsp_pkg::COUNT_W-1:0] write_count
);

	localparam int LAT_N = ddrsp_pkg::LAT_LONG_CYC;
	localparam int TAP_LONG = ddrsp_pkg::LAT_LONG_CYC - 1;
	localparam int TAP_SHORT = ddrsp_pkg::LAT_SHORT_CYC - 1;

	// ------------------------------------------------------------
	// state types
	// ------------------------------------------------------------
	typedef struct packed {
		logic r1;
		logic r2;
	} ddrsp_rst_t;

	typedef struct packed {
		logic block;
		logic [LAT_N-1:0] rd_v;
		logic [LAT_N-1:0][ADDR_W-1:0] rd_a;
		logic wr_pend;
		logic [ADDR_W-1:0] wr_addr;
		logic wr_commit;
		logic [ADDR_W-1:0] commit_addr;
		logic [DATA_W-1:0] w0;
		logic tog;
		logic [DATA_W-1:0] q0;
		logic [DATA_W-1:0] q1_hold;
		logic vld;
		logic oe_n;
		logic rd_tog;
		logic wr_tog;
	} ddrsp_k_t;

	typedef struct packed {
		logic tog;
		logic [DATA_W-1:0] w1;
		logic [DATA_W-1:0] q1;
		logic vld;
		logic oe_n;
	} ddrsp_kn_t;

	typedef struct packed {
		logic last_rd;
		logic last_wr;
		logic [ddrsp_pkg::COUNT_W-1:0] rd_cnt;
		logic [ddrsp_pkg::COUNT_W-1:0] wr_cnt;
	} ddrsp_sys_t;

	ddrsp_rst_t rs;
	ddrsp_rst_t next_rs;
	ddrsp_k_t k;
	ddrsp_k_t next_k;
	ddrsp_kn_t kn;
	ddrsp_kn_t next_kn;
	ddrsp_sys_t sys;
	ddrsp_sys_t next_sys;

	logic k_rst_n;
	logic lat_long_k;
	logic accept;
	logic launch;
	logic sel_k;
	logic [2:0] sys_sync;
	logic tap_v;
	logic [ADDR_W-1:0] tap_a;
	logic [DATA_W-1:0] line_lo;
	logic [DATA_W-1:0] line_hi;
	logic rd_event;
	logic wr_event;

	ddrsp_mem_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mem ();

	// ------------------------------------------------------------
	// reset release into the link domain
	// ------------------------------------------------------------
	always_comb begin
		next_rs.r1 = ddrsp_pkg::RST_RELEASE;
		next_rs.r2 = rs.r1;
	end

	always_ff @(posedge k_clk or negedge reset_n) begin
		if (!reset_n) begin
			rs <= '0;
		end else begin
			rs <= next_rs;
		end
	end

	// link logic leaves reset two k edges after reset_n rises
	assign k_rst_n = rs.r2;

	// ------------------------------------------------------------
	// latency strap brought onto k
	// ------------------------------------------------------------
	ddrsp_sync #(.WIDTH(1)) u_lat_sync (
		.clock(k_clk),
		.reset_n(k_rst_n),
		.enable(1'h1),
		.din(latency_select_input),
		.dout(lat_long_k)
	);

	// ------------------------------------------------------------
	// storage array
	// ------------------------------------------------------------
	ddrsp_array #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_array (
		.k_clk(k_clk),
		.mem(mem.store)
	);

	// ------------------------------------------------------------
	// read tap: pipeline stage that matches the strapped latency
	// ------------------------------------------------------------
	always_comb begin
		if (lat_long_k) begin
			tap_v = k.rd_v[TAP_LONG];
			tap_a = k.rd_a[TAP_LONG];
		end else begin
			tap_v = k.rd_v[TAP_SHORT];
			tap_a = k.rd_a[TAP_SHORT];
		end
	end

	// the low half of a stored line is word 0, the high half word 1
	assign line_lo = mem.rdata[DATA_W-1:0];
	assign line_hi = mem.rdata[ddrsp_pkg::BURST_WORDS*DATA_W-1:DATA_W];

	// ------------------------------------------------------------
	// k rising edge: command, write word 0, read launch
	// ------------------------------------------------------------
	always_comb begin
		next_k = k;
		next_k.tog = ~k.tog;
		// the edge after an accepted address is a data-only edge
		accept = !cmd_load_n && !k.block;
		next_k.block = accept;
		// read pipeline, one stage per cycle of latency
		next_k.rd_v[0] = accept && cmd_write_n;
		next_k.rd_a[0] = cmd_addr;
		for (int i = 1; i < LAT_N; i++) begin
			next_k.rd_v[i] = k.rd_v[i-1];
			next_k.rd_a[i] = k.rd_a[i-1];
		end
		// write address now, words on the following k and k_n edges
		next_k.wr_pend = accept && !cmd_write_n;
		if (accept) begin
			next_k.wr_addr = cmd_addr;
		end
		next_k.wr_commit = k.wr_pend;
		if (k.wr_pend) begin
			next_k.w0 = dq_in;
			next_k.commit_addr = k.wr_addr;
			next_k.wr_tog = ~k.wr_tog;
		end
		// launch point picked by the strap
		launch = tap_v;
		next_k.vld = launch;
		next_k.oe_n = launch ? ddrsp_pkg::OE_ON : ddrsp_pkg::OE_OFF;
		if (launch) begin
			next_k.q0 = line_lo;
			next_k.q1_hold = line_hi;
			next_k.rd_tog = ~k.rd_tog;
		end
	end

	always_ff @(posedge k_clk or negedge k_rst_n) begin
		if (!k_rst_n) begin
			k <= '0;
			k.oe_n <= ddrsp_pkg::OE_OFF;
		end else begin
			k <= next_k;
		end
	end

	// ------------------------------------------------------------
	// array access
	// ------------------------------------------------------------
	always_comb begin
		mem.we = k.wr_commit;
		mem.waddr = k.commit_addr;
		mem.wdata = {kn.w1, k.w0};
		mem.raddr = tap_a;
	end

	// ------------------------------------------------------------
	// k_n rising edge: write word 1, read word 1
	// ------------------------------------------------------------
	always_comb begin
		next_kn = kn;
		// k_n copies the k toggle, so the echo is high in the half after a k rise
		next_kn.tog = k.tog;
		// word 1 is taken on every k_n rise; only a committed line is stored
		next_kn.w1 = dq_in;
		next_kn.q1 = k.q1_hold;
		next_kn.vld = k.vld;
		next_kn.oe_n = k.oe_n;
	end

	always_ff @(posedge k_clk_n or negedge k_rst_n) begin
		if (!k_rst_n) begin
			kn <= '0;
			kn.oe_n <= ddrsp_pkg::OE_OFF;
		end else begin
			kn <= next_kn;
		end
	end

	// ------------------------------------------------------------
	// pin drive: whichever edge toggled last owns the pins
	// ------------------------------------------------------------
	// only the register whose edge came last may drive the pins
	assign sel_k = k.tog ^ kn.tog;
	assign dq_out = sel_k ? k.q0 : kn.q1;
	assign dq_oe_n = {DATA_W{sel_k ? k.oe_n : kn.oe_n}};
	assign read_valid_flag = sel_k ? k.vld : kn.vld;

	// ------------------------------------------------------------
	// echo clocks: high in the half after a k rise, low after k_n
	// ------------------------------------------------------------
	assign read_echo_clock = sel_k;
	assign read_echo_clock_n = ~sel_k;

	// ------------------------------------------------------------
	// status crossing into the system domain
	// ------------------------------------------------------------
	ddrsp_sync #(.WIDTH(3)) u_sys_sync (
		.clock(clock),
		.reset_n(reset_n),
		.enable(clock_enable),
		.din({lat_long_k, k.wr_tog, k.rd_tog}),
		.dout(sys_sync)
	);

	// toggles closer than a few system cycles may merge into one count
	assign rd_event = sys_sync[0] != sys.last_rd;
	assign wr_event = sys_sync[1] != sys.last_wr;

	always_comb begin
		next_sys = sys;
		next_sys.last_rd = sys_sync[0];
		next_sys.last_wr = sys_sync[1];
		if (rd_event) begin
			next_sys.rd_cnt = sys.rd_cnt + ddrsp_pkg::COUNT_STEP;
		end
		if (wr_event) begin
			next_sys.wr_cnt = sys.wr_cnt + ddrsp_pkg::COUNT_STEP;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sys <= '0;
		end else if (clock_enable) begin
			sys <= next_sys;
		end
	end

	assign latency_long = sys_sync[2];
	assign read_count = sys.rd_cnt;
	assign write_count = sys.wr_cnt;

endmodule

// >>> bench/ddrsp_assertions.sv
// assertions on the ports of the sram port top
`timescale 1ns/10ps
module ddrsp_assertions #(
	parameter int DATA_W = 18
) (
	// clocks and reset
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clock_enable,
	input wire logic k_clk,
	input wire logic k_clk_n,
	// link
	input wire logic cmd_load_n,
	input wire logic cmd_write_n,
	input wire logic [DATA_W-1:0] dq_oe_n,
	input wire logic read_echo_clock,
	input wire logic read_echo_clock_n,
	input wire logic read_valid_flag,
	input wire logic latency_select_input,
	// status
	input wire logic latency_long,
	input wire logic [ddrsp_pkg::COUNT_W-1:0] read_count
);
	logic tk;
	logic [2:0] rd;
	logic [3:0] up;
	wire go = !cmd_load_n && !tk;
	always_ff @(posedge k_clk or negedge reset_n) begin
		if (!reset_n) begin
			tk <= 1'b0;
			rd <= 3'h0;
			up <= 4'h0;
		end else begin
			tk <= go;
			rd <= {rd[1:0], go && cmd_write_n};
			up <= {up[2:0], 1'b1};
		end
	end
	property p_lat_long;
		@(posedge k_clk) disable iff (!reset_n)
		go && cmd_write_n && latency_select_input |-> ##3 read_valid_flag && dq_oe_n == '0;
	endproperty
	a_lat_long: assert property (p_lat_long) else $error("late read");
	property p_lat_short;
		@(posedge k_clk) disable iff (!reset_n)
		go && cmd_write_n && !latency_select_input |-> ##2 read_valid_flag && dq_oe_n == '0;
	endproperty
	a_lat_short: assert property (p_lat_short) else $error("late read");
	property p_valid_only;
		@(posedge k_clk) disable iff (!reset_n)
		read_valid_flag |-> (latency_select_input ? rd[2] : rd[1]);
	endproperty
	a_valid_only: assert property (p_valid_only) else $error("stray valid");
	property p_oe_valid;
		@(posedge k_clk) disable iff (!reset_n) read_valid_flag == (dq_oe_n == '0);
	endproperty
	a_oe_valid: assert property (p_oe_valid) else $error("pin drive");
	property p_echo;
		@(posedge k_clk_n) disable iff (!reset_n) up[3] |-> read_echo_clock;
	endproperty
	a_echo: assert property (p_echo) else $error("echo phase");
	property p_echo_low;
		@(posedge k_clk) disable iff (!reset_n) up[3] |-> !read_echo_clock;
	endproperty
	a_echo_low: assert property (p_echo_low) else $error("echo low phase");
	property p_echo_pair;
		@(posedge k_clk_n) disable iff (!reset_n) read_echo_clock_n == !read_echo_clock;
	endproperty
	a_echo_pair: assert property (p_echo_pair) else $error("echo pair");
	property p_rcount_step;
		@(posedge clock) disable iff (!reset_n)
		$changed(read_count) |-> read_count == $past(read_count) + ddrsp_pkg::COUNT_STEP;
	endproperty
	a_rcount_step: assert property (p_rcount_step) else $error("count step");
	property p_count_hold;
		@(posedge clock) disable iff (!reset_n) !clock_enable |=> $stable(read_count);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("count moved");
	property p_strap;
		@(posedge clock) disable iff (!reset_n) latency_long |-> latency_select_input;
	endproperty
	a_strap: assert property (p_strap) else $error("strap");
	c_write: cover property (@(posedge k_clk) go && !cmd_write_n);
	c_read: cover property (@(posedge k_clk) go && cmd_write_n);
	c_refused: cover property (@(posedge k_clk) !cmd_load_n && tk);
endmodule
bind ddrsp_top ddrsp_assertions #(.DATA_W(DATA_W)) ddrsp_assertions_inst (.clock, .reset_n, .clock_enable,
	.k_clk, .k_clk_n, .cmd_load_n, .cmd_write_n, .dq_oe_n, .read_echo_clock, .read_echo_clock_n, .read_valid_flag,
	.latency_select_input, .latency_long, .read_count);

// >>> bench/ddrsp_ctl_model.sv
// memory controller model on the link side
`timescale 1ns/10ps
module ddrsp_ctl_model #(
	parameter int ADDR_W = 4,
	parameter int DATA_W = 18
) (
	// link clocks and command
	output logic k_clk,
	output logic k_clk_n,
	output logic cmd_load_n,
	output logic cmd_write_n,
	output logic [ADDR_W-1:0] cmd_addr,
	// data pins
	output logic [DATA_W-1:0] dq_in,
	input wire logic [DATA_W-1:0] dq_out,
	input wire logic read_echo_clock,
	input wire logic read_valid_flag
);
	assign k_clk_n = ~k_clk;
	initial begin
		cmd_load_n = 1'b1;
		cmd_write_n = 1'b1;
		cmd_addr = '0;
		dq_in = '0;
		k_clk = 1'b0;
		#3.3;
		forever #15 k_clk = ~k_clk;
	end
	// call just after a k fall; dbl holds load low one edge too long
	task automatic send(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0,
		input logic [DATA_W-1:0] d1, input int gap, input logic dbl,
		output logic [DATA_W-1:0] q0, output logic [DATA_W-1:0] q1, output logic [3:0] n);
		logic got;
		got = 1'b0;
		n = 4'h0;
		q0 = '0;
		q1 = '0;
		repeat (gap) @(negedge k_clk);
		cmd_load_n = 1'b0;
		cmd_write_n = rd;
		cmd_addr = a;
		@(posedge k_clk);
		#1 cmd_load_n = !dbl;
		cmd_addr = ~a;
		dq_in = rd ? ~dq_in : d0;
		if (!rd) begin
			@(posedge k_clk);
			#1 cmd_load_n = 1'b1;
			dq_in = d1;
			@(posedge k_clk_n);
			#1 dq_in = ~d1;
		end
		while (rd && !got && n < 4'h4) begin
			@(posedge read_echo_clock);
			#1 n++;
			dq_in = ~dq_in;
			if (read_valid_flag) begin
				got = 1'b1;
				q0 = dq_out;
				@(negedge read_echo_clock);
				#1 q1 = dq_out;
			end
		end
	endtask
endmodule

// >>> bench/ddr_two_word_burst_sram_port_test.sv
// self-checking bench for the sram port
`timescale 1ns/10ps
module ddr_two_word_burst_sram_port_test;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic clock_enable = 1'b1;
	logic latency_select_input = 1'b1;
	logic k_clk, k_clk_n, cmd_load_n, cmd_write_n, read_echo_clock, read_echo_clock_n;
	logic read_valid_flag, latency_long;
	logic [3:0] cmd_addr, n;
	logic [17:0] dq_in, dq_out, dq_oe_n, w0, w1;
	logic [15:0] read_count, write_count;
	logic [31:0] seed = 32'h7657_b040;
	logic [35:0] mem [16];
	int fails = 0;
	int checks = 0;
	always #25 clock = ~clock;
	ddrsp_top #(.ADDR_W(4)) ddrsp_top_inst (.clock, .reset_n, .clock_enable, .k_clk, .k_clk_n,
		.cmd_load_n, .cmd_write_n, .cmd_addr, .dq_in, .dq_out, .dq_oe_n, .read_echo_clock,
		.read_echo_clock_n, .read_valid_flag, .latency_select_input, .latency_long, .read_count,
		.write_count);
	ddrsp_ctl_model ddrsp_ctl_model_inst (.k_clk, .k_clk_n, .cmd_load_n, .cmd_write_n, .cmd_addr,
		.dq_in, .dq_out, .read_echo_clock, .read_valid_flag);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input int gap, input logic dbl);
		seed = lfsr(seed);
		mem[a] = {seed[31:14], seed[17:0]};
		ddrsp_ctl_model_inst.send(1'b0, a, mem[a][17:0], mem[a][35:18], gap, dbl, w0, w1, n);
	endtask
	task automatic rd(input logic [3:0] a, input int gap);
		ddrsp_ctl_model_inst.send(1'b1, a, '0, '0, gap, 1'b0, w0, w1, n);
		check(n, latency_select_input ? 4'h2 : 4'h1);
		check(w0, mem[a][17:0]);
		check(w1, mem[a][35:18]);
	endtask
	// -----------------------------------------------
	// one pass per latency strap value
	// -----------------------------------------------
	task automatic pass(input logic l);
		@(negedge clock);
		reset_n = 1'b0;
		latency_select_input = l;
		repeat (5) @(negedge clock);
		reset_n = 1'b1;
		repeat (10) @(negedge k_clk);
		for (int a = 0; a < 16; a++)
			wr(a[3:0], 10, 1'b0);
		repeat (20) @(negedge clock);
		check(write_count, 16'h0010);
		for (int a = 0; a < 16; a++)
			rd(a[3:0], 10);
		repeat (20) @(negedge clock);
		check(read_count, 16'h0010);
		check(latency_long, l);
		// a read while the system side is frozen is counted only after the enable returns
		clock_enable = 1'b0;
		rd(4'h7, 10);
		repeat (10) @(negedge clock);
		check(read_count, 16'h0010);
		clock_enable = 1'b1;
		repeat (20) @(negedge clock);
		check(read_count, 16'h0011);
		wr(4'h3, 0, 1'b0);
		rd(4'h3, 0);
		wr(4'h5, 0, 1'b1);
		rd(4'ha, 0);
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			rd(seed[3:0], 0);
		end
		@(negedge clock);
		clock_enable = 1'b0;
		repeat (10) @(negedge clock);
		clock_enable = 1'b1;
		$display("latency strap %0d done", l);
	endtask
	initial begin
		pass(1'b1);
		pass(1'b0);
		results();
	end
	initial begin
		#200000;
		fails++;
		results();
	end
endmodule
